//--- hw/can_rx_id_filter.sv
// receive identifier filter with priority flag and register port
`default_nettype none
module can_rx_id_filter #(
  parameter int NS = rx_filter_pkg::NUM_STD,
  parameter int NE = rx_filter_pkg::NUM_EXT
) (
  // clock and reset
  input  wire logic              clock_i,
  input  wire logic              srst_i,
  // register port
  input  wire logic [rx_filter_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic [31:0]            rdata_o,
  // received frame from the bus side
  input  wire logic              frame_valid_i,
  input  wire logic              frame_ext_i,
  input  wire logic [rx_filter_pkg::EXT_ID_W-1:0] frame_id_i,
  // filter verdict
  output logic                   accept_o,
  output logic                   store_fifo0_o,
  output logic                   store_fifo1_o,
  output logic                   high_priority_message_o,
  output logic                   irq_o
);
  import rx_filter_pkg::*;
  // std element word: [31:30] type [29:27] config [26:16] a [10:0] b
  // ext word A: [31:29] config [28:0] a ; word B: [31:30] type [28:0] b
  typedef struct packed {
    logic [NS-1:0][31:0] std_elem;
    logic [NE-1:0][31:0] ext_a;
    logic [NE-1:0][31:0] ext_b;
    logic [1:0]          nm_std;
    logic [1:0]          nm_ext;
    logic [ST_W-1:0]     status;
    logic [ST_W-1:0]     mask;
    logic [7:0]          result;
    logic [31:0]         rdata;
    logic                accept;
    logic                f0;
    logic                f1;
    logic                high_priority_message;
    logic                irq;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic [NS-1:0] std_hit;
  logic [NE-1:0] ext_hit;

  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_std
      id_match_elem #(.W(STD_ID_W)) u_m (
        .ftype_i   (s_q.std_elem[g][31:30]),
        .field_a_i (s_q.std_elem[g][26:16]),
        .field_b_i (s_q.std_elem[g][10:0]),
        .id_i      (frame_id_i[STD_ID_W-1:0]),
        .hit_o     (std_hit[g])
      );
    end
    for (g = 0; g < NE; g++) begin : g_ext
      id_match_elem #(.W(EXT_ID_W)) u_m (
        .ftype_i   (s_q.ext_b[g][31:30]),
        .field_a_i (s_q.ext_a[g][28:0]),
        .field_b_i (s_q.ext_b[g][28:0]),
        .id_i      (frame_id_i),
        .hit_o     (ext_hit[g])
      );
    end
  endgenerate

  function automatic logic [2:0] std_cfg(input logic [31:0] w);
    std_cfg = w[29:27];
  endfunction : std_cfg

  // first enabled matching element wins, lowest index first
  logic        matched;
  logic [2:0]  hit_cfg;
  logic [IDX_W-1:0] hit_idx;
  logic        prio;
  dest_t       dest;
  logic [1:0]  nm;
  logic        take;
  logic [ST_W-1:0] ev;
  logic [ST_W-1:0] clr;

  always_comb begin
    matched = 1'b0;
    hit_cfg = EC_DISABLE;
    hit_idx = '0;
    if (frame_ext_i) begin
      for (int i = NE - 1; i >= 0; i--) begin
        if (ext_hit[i] && s_q.ext_a[i][31:29] != EC_DISABLE) begin
          matched = 1'b1;
          hit_cfg = s_q.ext_a[i][31:29];
          hit_idx = IDX_W'(i);
        end
      end
    end else begin
      for (int i = NS - 1; i >= 0; i--) begin
        if (std_hit[i] && std_cfg(s_q.std_elem[i]) != EC_DISABLE) begin
          matched = 1'b1;
          hit_cfg = std_cfg(s_q.std_elem[i]);
          hit_idx = IDX_W'(i);
        end
      end
    end
    nm = frame_ext_i ? s_q.nm_ext : s_q.nm_std;
    prio = 1'b0;
    dest = DEST_NONE;
    if (matched) begin
      case (hit_cfg)
        EC_FIFO0:   dest = DEST_F0; // see RULE_07 RULE_08
        EC_FIFO1:   dest = DEST_F1; // see RULE_07 RULE_08
        EC_PRIO:    prio = 1'b1; // see RULE_01 RULE_02 RULE_14
        EC_PRIO_F0: begin
          prio = 1'b1; // see RULE_01 RULE_02
          dest = DEST_F0; // see RULE_14
        end
        EC_PRIO_F1: begin
          prio = 1'b1; // see RULE_01 RULE_02
          dest = DEST_F1; // see RULE_14
        end
        default:    dest = DEST_NONE;
      endcase
    end else begin
      // priority is worked out per frame, never carried over
      case (nm)
        NM_FIFO0: dest = DEST_F0; // see RULE_04 RULE_05 RULE_06
        NM_FIFO1: dest = DEST_F1; // see RULE_04 RULE_05 RULE_06
        default:  dest = DEST_NONE;
      endcase
    end
    take = frame_valid_i && (dest != DEST_NONE || prio);
  end

  always_comb begin
    s_d = s_q;
    ev = '0;
    clr = '0;
    s_d.accept = 1'b0;
    s_d.f0 = 1'b0;
    s_d.f1 = 1'b0;
    s_d.high_priority_message = 1'b0;
    s_d.rdata = '0;
    if (frame_valid_i) begin
      s_d.accept = take;
      s_d.f0 = (dest == DEST_F0);
      s_d.f1 = (dest == DEST_F1);
      s_d.high_priority_message = prio; // see RULE_03 RULE_06
      s_d.result = {frame_ext_i, matched, prio, hit_idx[1:0],
                    hit_cfg};
      ev[ST_HPM] = prio; // see RULE_03
      ev[ST_RX0] = (dest == DEST_F0);
      ev[ST_RX1] = (dest == DEST_F1);
      ev[ST_DROP] = !take;
    end
    if (wr_i) begin
      if (addr_i == A_GLOBAL) begin
        s_d.nm_std = wdata_i[1:0];
        s_d.nm_ext = wdata_i[3:2];
      end
      if (addr_i == A_STATUS) begin
        clr = wdata_i[ST_W-1:0];
      end
      if (addr_i == A_MASK) begin
        s_d.mask = wdata_i[ST_W-1:0];
      end
      for (int i = 0; i < NS; i++) begin
        if (addr_i == A_STD_BASE + ADDR_W'(4 * i)) begin
          s_d.std_elem[i] = wdata_i;
        end
      end
      for (int i = 0; i < NE; i++) begin
        if (addr_i == A_EXT_BASE + ADDR_W'(4 * i)) begin
          s_d.ext_a[i] = wdata_i;
        end
        if (addr_i == A_EXT_B + ADDR_W'(4 * i)) begin
          s_d.ext_b[i] = wdata_i;
        end
      end
    end
    // a new event beats a clear in the same cycle
    s_d.status = (s_q.status & ~clr) | ev;
    if (rd_i) begin
      case (addr_i)
        A_GLOBAL: s_d.rdata = {28'h0, s_q.nm_ext, s_q.nm_std};
        A_STATUS: s_d.rdata = {28'h0, s_q.status};
        A_MASK:   s_d.rdata = {28'h0, s_q.mask};
        A_RESULT: s_d.rdata = {24'h0, s_q.result};
        default: begin
          for (int i = 0; i < NS; i++) begin
            if (addr_i == A_STD_BASE + ADDR_W'(4 * i)) begin
              s_d.rdata = s_q.std_elem[i];
            end
          end
          for (int i = 0; i < NE; i++) begin
            if (addr_i == A_EXT_BASE + ADDR_W'(4 * i)) begin
              s_d.rdata = s_q.ext_a[i];
            end
            if (addr_i == A_EXT_B + ADDR_W'(4 * i)) begin
              s_d.rdata = s_q.ext_b[i];
            end
          end
        end
      endcase
    end
    s_d.irq = |(s_d.status & s_q.mask);
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      s_q <= '0;
      s_q.nm_std <= GLOBAL_RST;
      s_q.nm_ext <= GLOBAL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rdata;
  assign accept_o = s_q.accept;
  assign store_fifo0_o = s_q.f0;
  assign store_fifo1_o = s_q.f1;
  assign high_priority_message_o = s_q.high_priority_message;
  assign irq_o = s_q.irq;
endmodule : can_rx_id_filter
`default_nettype wire

//--- include/rx_filter_pkg.sv
// package of constants and types for the receive identifier filter
// Notes on behaviour
// RULE_01: standard element config 100, 101 or 110 marks a priority filter.
// RULE_02: extended element config 100, 101 or 110 marks a priority filter.
// RULE_03: frame accepted by a priority element sets the high priority flag.
// RULE_04: accept_nonmatching_ext 00 or 01 accepts unmatched extended frames.
// RULE_05: accept_nonmatching_std 00 or 01 accepts unmatched standard frames.
// RULE_06: frames accepted only by global setting never set the priority flag.
// RULE_07: extended config 001 stores in fifo 0, 010 in fifo 1.
// RULE_08: standard config 001 stores in fifo 0, 010 in fifo 1.
// RULE_09: extended type 10 is classic: field a value, field b mask.
// RULE_10: standard type 10 is classic: field a value, field b mask.
// RULE_11: extended classic mask of zero matches every extended identifier.
// RULE_12: standard classic mask of zero matches every standard identifier.
// RULE_13: with one format prioritised, software adds other-format catch-all.
// RULE_14: config 100 flags only; 101 and 110 flag and store in fifo 0/1.
`default_nettype none
package rx_filter_pkg;
  localparam int STD_ID_W = 11;
  localparam int EXT_ID_W = 29;
  localparam int NUM_STD  = 4;
  localparam int NUM_EXT  = 4;
  localparam int IDX_W    = 3;
  // element configuration codes
  localparam logic [2:0] EC_DISABLE = 3'h0;
  localparam logic [2:0] EC_FIFO0   = 3'h1;
  localparam logic [2:0] EC_FIFO1   = 3'h2;
  localparam logic [2:0] EC_REJECT  = 3'h3;
  localparam logic [2:0] EC_PRIO    = 3'h4;
  localparam logic [2:0] EC_PRIO_F0 = 3'h5;
  localparam logic [2:0] EC_PRIO_F1 = 3'h6;
  // filter type codes
  localparam logic [1:0] FT_RANGE   = 2'h0;
  localparam logic [1:0] FT_DUAL    = 2'h1;
  localparam logic [1:0] FT_CLASSIC = 2'h2;
  // global non-matching codes
  localparam logic [1:0] NM_FIFO0   = 2'h0;
  localparam logic [1:0] NM_FIFO1   = 2'h1;
  // register map (word offsets are byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [7:0] A_GLOBAL   = 8'h00;
  localparam logic [7:0] A_STATUS   = 8'h04;
  localparam logic [7:0] A_MASK     = 8'h08;
  localparam logic [7:0] A_RESULT   = 8'h0c;
  localparam logic [7:0] A_STD_BASE = 8'h40;
  localparam logic [7:0] A_EXT_BASE = 8'h80;
  localparam logic [7:0] A_EXT_B    = 8'hc0;
  // status bits
  localparam int ST_HPM  = 0;
  localparam int ST_RX0  = 1;
  localparam int ST_RX1  = 2;
  localparam int ST_DROP = 3;
  localparam int ST_W    = 4;
  localparam logic [31:0] RESET_WORD = 32'h0;
  localparam logic [1:0]  GLOBAL_RST = 2'h0;
  typedef enum logic [1:0] {DEST_NONE, DEST_F0, DEST_F1} dest_t;
endpackage : rx_filter_pkg
`default_nettype wire

//--- hw/id_match_elem.sv
// one filter element compare: range, dual id or classic mask
`default_nettype none
module id_match_elem #(
  parameter int W = 11
) (
  // element setup
  input  wire logic [1:0]   ftype_i,
  input  wire logic [W-1:0] field_a_i,
  input  wire logic [W-1:0] field_b_i,
  // frame identifier
  input  wire logic [W-1:0] id_i,
  output logic              hit_o
);
  import rx_filter_pkg::*;
  logic [W-1:0] diff;
  always_comb begin
    // zero mask bits drop out, so an all-zero mask hits always
    diff = (id_i ^ field_a_i) & field_b_i; // see RULE_11 RULE_12
    case (ftype_i)
      FT_RANGE:   hit_o = (id_i >= field_a_i) && (id_i <= field_b_i);
      FT_DUAL:    hit_o = (id_i == field_a_i) || (id_i == field_b_i);
      FT_CLASSIC: hit_o = (diff == '0); // see RULE_09 RULE_10
      default:    hit_o = 1'b0;
    endcase
  end
endmodule : id_match_elem
`default_nettype wire

//--- bench/rx_filter_chk.sv
// port assertions for the receive identifier filter
`default_nettype none
module rx_filter_chk
  import rx_filter_pkg::*;
(
  // clock, reset and register port
  input wire logic                               clock_i,
  input wire logic                               srst_i,
  input wire logic [rx_filter_pkg::ADDR_W-1:0]   addr_i,
  input wire logic [31:0]                        wdata_i,
  input wire logic                               wr_i,
  input wire logic                               rd_i,
  input wire logic [31:0]                        rdata_o,
  // frame and verdict
  input wire logic                               frame_valid_i,
  input wire logic                               frame_ext_i,
  input wire logic [rx_filter_pkg::EXT_ID_W-1:0] frame_id_i,
  input wire logic                               accept_o,
  input wire logic                               store_fifo0_o,
  input wire logic                               store_fifo1_o,
  input wire logic                               high_priority_message_o,
  input wire logic                               irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  chk_accept_cause:
    assert property (accept_o |-> $past(frame_valid_i))
      else $error("stray accept");
  chk_fifo0_only:
    assert property (store_fifo0_o |-> accept_o && !store_fifo1_o)
      else $error("bad fifo0");
  chk_fifo1_only:
    assert property (store_fifo1_o |-> accept_o && !store_fifo0_o)
      else $error("bad fifo1");
  chk_prio_accept:
    assert property (high_priority_message_o |-> accept_o)
      else $error("prio w/o accept");
  chk_prio_no_stale:
    assert property (high_priority_message_o && !frame_valid_i
                     |=> !high_priority_message_o)
      else $error("stale prio flag");
  // a mask write reaches irq_o one edge later than a status clear
  chk_irq_rise:
    assert property ($rose(irq_o)
                     |-> $past(frame_valid_i) || $past(wr_i, 2))
      else $error("irq rose without cause");
  chk_irq_fall:
    assert property ($fell(irq_o) |-> $past(wr_i) || $past(wr_i, 2))
      else $error("irq fell without write");
  chk_read_window:
    assert property (rdata_o != 32'h0 |-> $past(rd_i))
      else $error("rdata outside window");
  cover property (high_priority_message_o && store_fifo1_o);
  cover property (store_fifo0_o && !high_priority_message_o);
  cover property ($rose(irq_o));
endmodule : rx_filter_chk
`default_nettype wire

//--- bench/can_node.sv
// model of the other bus nodes: presents received identifiers
`default_nettype none
module can_node (
  // clock
  input  wire logic        clock_i,
  // received frame
  output var  logic        frame_valid_o,
  output var  logic        frame_ext_o,
  output var  logic [28:0] frame_id_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    frame_valid_o = 1'b0;
    frame_ext_o   = 1'b0;
    frame_id_o    = 29'h0;
  end
  // one frame per call; calls at successive edges go back to back
  task automatic send(input logic ext, input logic [28:0] id);
    @(posedge clock_i);
    frame_valid_o <= 1'b1;
    frame_ext_o   <= ext;
    frame_id_o    <= ext ? id : {18'h0, id[10:0]};
  endtask : send
  // idle lines no longer show the last identifier
  task automatic idle();
    @(posedge clock_i);
    frame_valid_o <= 1'b0;
    frame_ext_o   <= ~frame_ext_o;
    frame_id_o    <= ~frame_id_o;
  endtask : idle
endmodule : can_node
`default_nettype wire

//--- bench/tb.sv
// self-checking bench for the receive identifier filter
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rx_filter_pkg::*;
  logic clock_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic fv_d = 1'b0, rd_d = 1'b0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [31:0] wdata_i = 32'h0, rdata_o;
  logic accept_o, store_fifo0_o, store_fifo1_o, high_priority_message_o, irq_o;
  wire logic fv, fe;
  wire logic [EXT_ID_W-1:0] fid;
  logic [31:0] vq[$], rq[$];
  logic [31:0] verdict;
  assign verdict = {28'h0, accept_o, store_fifo0_o, store_fifo1_o,
                    high_priority_message_o};
  logic [28:0] pid, oid;
  int mismatches = 0, samples_checked = 0;
  integer seed = 32'h043adb8c;
  always #25 clock_i = ~clock_i;
  can_rx_id_filter i_dut (.clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .frame_valid_i(fv), .frame_ext_i(fe), .frame_id_i(fid), .accept_o(accept_o),
    .store_fifo0_o(store_fifo0_o), .store_fifo1_o(store_fifo1_o),
    .high_priority_message_o(high_priority_message_o), .irq_o(irq_o));
  can_node i_node (.clock_i(clock_i), .frame_valid_o(fv), .frame_ext_o(fe),
    .frame_id_o(fid));
  task automatic final_report();
    if (mismatches == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report
  task automatic check(input string what, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  function automatic logic [31:0] ex(input logic a, f0, f1, h);
    return {28'h0, a, f0, f1, h};
  endfunction : ex
  // read data rides in wdata_i too; harmless since wr_i is low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    wr_i <= w;
    rd_i <= !w;
    addr_i <= a;
    wdata_i <= d;
    if (!w) rq.push_back(d);
    @(posedge clock_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
  endtask : bus
  task automatic elem(input logic ext, input logic [2:0] cfg,
                      input logic [1:0] ft, input logic [28:0] a, b);
    if (ext) begin
      bus(1'b1, A_EXT_BASE, {cfg, a});
      bus(1'b1, A_EXT_B, {ft, 1'b0, b});
    end else
      bus(1'b1, A_STD_BASE, {ft, cfg, a[10:0], 5'h0, b[10:0]});
  endtask : elem
  task automatic frame(input logic ext, input logic [28:0] id, input logic [31:0] e);
    i_node.send(ext, id);
    vq.push_back(e);
  endtask : frame
  always @(posedge clock_i) begin
    fv_d <= fv;
    rd_d <= rd_i;
    if (fv_d) check("verdict", vq.pop_front(), verdict);
    if (rd_d) check("rdata", rq.pop_front(), rdata_o);
  end
  initial begin
    #(50 * 5000);
    mismatches++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge clock_i);
    srst_i <= 1'b0;
    bus(1'b0, A_GLOBAL, 32'h0);
    bus(1'b0, 8'h30, 32'h0);
    bus(1'b1, A_MASK, 32'h1);
    for (int fmt = 0; fmt < 2; fmt++)
      for (int code = 4; code < 7; code++)
        for (int nm = 0; nm < 2; nm++) begin
          pid = 29'($random(seed));
          oid = 29'($random(seed));
          elem(!fmt[0], EC_DISABLE, FT_CLASSIC, 29'h0, 29'h0);
          elem(fmt[0], code[2:0], FT_CLASSIC, pid, '1);
          // only the opposite format takes unmatched frames
          bus(1'b1, A_GLOBAL, fmt ? {28'h0, 2'h2, nm[1:0]} : {28'h0, nm[1:0], 2'h2});
          frame(fmt[0], pid, ex(1'b1, code == 5, code == 6, 1'b1));
          frame(!fmt[0], oid, ex(1'b1, nm == 0, nm == 1, 1'b0));
          frame(fmt[0], pid ^ 29'h1, ex(1'b0, 1'b0, 1'b0, 1'b0));
          i_node.idle();
          elem(!fmt[0], nm ? EC_FIFO1 : EC_FIFO0, FT_CLASSIC, oid, 29'h0);
          frame(fmt[0], pid, ex(1'b1, code == 5, code == 6, 1'b1));
          frame(!fmt[0], ~oid, ex(1'b1, nm == 0, nm == 1, 1'b0));
          i_node.idle();
        end
    bus(1'b0, A_EXT_BASE, {EC_PRIO_F1, pid});
    bus(1'b0, A_STATUS, 32'hf);
    check("irq", 32'h1, {31'h0, irq_o});
    bus(1'b1, A_STATUS, 32'h1);
    bus(1'b0, A_STATUS, 32'he);
    check("irq", 32'h0, {31'h0, irq_o});
    bus(1'b1, A_STATUS, 32'he);
    bus(1'b1, A_MASK, 32'h2);
    frame(1'b1, pid, ex(1'b1, 1'b0, 1'b1, 1'b1));
    i_node.idle();
    bus(1'b0, A_RESULT, 32'he6);
    bus(1'b0, A_STATUS, 32'h5);
    check("irq", 32'h0, {31'h0, irq_o});
    bus(1'b1, A_MASK, 32'h4);
    // the new mask shows on irq_o one edge after the write lands
    repeat (2) @(posedge clock_i);
    check("irq", 32'h1, {31'h0, irq_o});
    // range and dual-id types, and a reject element
    elem(1'b0, EC_FIFO0, FT_RANGE, 29'h100, 29'h1ff);
    frame(1'b0, 29'h180, ex(1'b1, 1'b1, 1'b0, 1'b0));
    frame(1'b0, 29'h200, ex(1'b1, 1'b0, 1'b1, 1'b0));
    i_node.idle();
    elem(1'b0, EC_REJECT, FT_DUAL, 29'h12, 29'h34);
    frame(1'b0, 29'h34, ex(1'b0, 1'b0, 1'b0, 1'b0));
    frame(1'b0, 29'h35, ex(1'b1, 1'b0, 1'b1, 1'b0));
    i_node.idle();
    repeat (2) @(posedge clock_i);
    final_report();
  end
endmodule : tb
bind can_rx_id_filter rx_filter_chk i_chk (.clock_i(clock_i), .srst_i(srst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .frame_valid_i(frame_valid_i), .frame_ext_i(frame_ext_i), .frame_id_i(frame_id_i),
  .accept_o(accept_o), .store_fifo0_o(store_fifo0_o), .store_fifo1_o(store_fifo1_o),
  .high_priority_message_o(high_priority_message_o), .irq_o(irq_o));
`default_nettype wire
